// *** design/ssw_top.sv ***
// Supply supervisor with release delay, manual reset and watchdog.
//
// Function
// R1: Assert reset from power-up onward.
// R2: Hold reset while undervoltage indication active.
// R3: Start delay only after supply above hysteresis.
// R4: Hold reset for release delay, then release.
// R5: Release delay fixed: 200 ms or 25 ms.
// R6: New undervoltage abandons delay, reasserts reset.
// R7: Low manual reset input forces reset.
// R8: Full release delay after manual reset released.
// R9: Unconnected manual reset reads high, inactive; design has no internal pull-up, relies on the board pull-up.
// R10: Kick level unchanged past timeout triggers reset.
// R11: Kick edge or reset clears watchdog timer.
// R12: Watchdog timeout fixed: 200 ms or 1.6 s.
// R13: Active-high output is complement of active-low.
// R14: Delays counted in ticks of internal time base.
`timescale 1ns/1ps

module ssw_top #(
    parameter bit SHORT_RELEASE = 1'b0,
    parameter bit SHORT_WDOG    = 1'b0,
    parameter bit WDOG_ENABLE   = 1'b1,
    parameter int unsigned TICK_DIV_P = ssw_pkg::TICK_DIV
) (
    input  wire logic SYS_CLK_I,
    input  wire logic RST_I,
    input  wire logic UNDERVOLTAGE_I,
    input  wire logic MANUAL_RESET_N_I,
    input  wire logic WATCHDOG_KICK_IN_I,
    output logic      RESET_N_O,
    output logic      RESET_O
);
    import ssw_pkg::*;

    // Durations chosen at build time, as tick counts.
    localparam logic [TICK_W-1:0] REL_TICKS = SHORT_RELEASE ?
        TICK_W'(RELEASE_SHORT_TICKS) : TICK_W'(RELEASE_STD_TICKS); // [R5]
    localparam logic [TICK_W-1:0] WD_TICKS = SHORT_WDOG ?
        TICK_W'(WDOG_SHORT_TICKS) : TICK_W'(WDOG_LONG_TICKS); // [R12]
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV_P - 1);
    localparam logic [TICK_W-1:0] CNT_ONE = {{(TICK_W-1){1'b0}}, 1'b1};
    localparam logic [DIV_W-1:0]  DIV_ONE = {{(DIV_W-1){1'b0}}, 1'b1};

    ssw_regs_t r_r;
    ssw_regs_t r_nxt;

    logic cause;
    logic kick_edge;
    logic wd_expire;

    always_comb begin
        r_nxt = r_r;
        // Two flip-flops in front of the undervoltage, manual reset and kick pins.
        r_nxt.s1.uv   = UNDERVOLTAGE_I;
        r_nxt.s1.man_n = MANUAL_RESET_N_I;
        r_nxt.s1.kick = WATCHDOG_KICK_IN_I;
        r_nxt.s2      = r_r.s1;
        r_nxt.kick_last = r_r.s2.kick;

        // Time base: one tick enable per divider period.
        r_nxt.tick = 1'b0; // [R14]
        if (r_r.div == DIV_LAST) begin
            r_nxt.div  = '0;
            r_nxt.tick = 1'b1;
        end else begin
            r_nxt.div = r_r.div + DIV_ONE;
        end

        // The undervoltage flag stays high until the supply passes the threshold plus hysteresis.
        cause = r_r.s2.uv || !r_r.s2.man_n; // [R2] [R3] [R7] [R9]

        kick_edge = r_r.s2.kick ^ r_r.kick_last;
        wd_expire = WDOG_ENABLE && (r_r.wd_cnt >= WD_TICKS);

        // Watchdog clears on a kick edge or while reset is asserted.
        if (kick_edge || !r_r.rst_n) begin
            r_nxt.wd_cnt = '0; // [R11]
        end else if (r_r.tick && !wd_expire) begin
            r_nxt.wd_cnt = r_r.wd_cnt + CNT_ONE;
        end

        unique case (r_r.state)
            ST_HOLD: begin
                r_nxt.rel_cnt = '0;
                if (!cause) begin
                    r_nxt.state = ST_RELEASE; // [R3] [R8]
                end
            end
            ST_RELEASE: begin
                if (cause) begin
                    r_nxt.state   = ST_HOLD; // [R6] [R7]
                    r_nxt.rel_cnt = '0;
                end else if (r_r.rel_cnt >= REL_TICKS) begin
                    r_nxt.state = ST_RUN; // [R4]
                end else if (r_r.tick) begin
                    r_nxt.rel_cnt = r_r.rel_cnt + CNT_ONE; // [R14]
                end
            end
            ST_RUN: begin
                r_nxt.rel_cnt = '0;
                if (cause) begin
                    r_nxt.state = ST_HOLD; // [R6] [R7]
                end else if (wd_expire) begin
                    r_nxt.state = ST_RELEASE; // [R10]
                end
            end
            default: begin
                r_nxt.state = ST_HOLD;
            end
        endcase

        r_nxt.rst_n = (r_nxt.state == ST_RUN); // [R2] [R4]
        r_nxt.rst   = !(r_nxt.state == ST_RUN); // [R13]
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            r_r.s1        <= '{uv: 1'b1, man_n: 1'b1, kick: 1'b0};
            r_r.s2        <= '{uv: 1'b1, man_n: 1'b1, kick: 1'b0};
            r_r.kick_last <= 1'b0;
            r_r.div       <= '0;
            r_r.tick      <= 1'b0;
            r_r.state     <= ST_HOLD; // [R1]
            r_r.rel_cnt   <= '0;
            r_r.wd_cnt    <= '0;
            r_r.rst_n     <= 1'b0; // [R1]
            r_r.rst       <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign RESET_N_O = r_r.rst_n;
    assign RESET_O   = r_r.rst; // [R13]

endmodule

// *** design/ssw_pkg.sv ***
// Package with constants and types of the supply supervisor watchdog.
package ssw_pkg;

    // Rate of the system clock and of the internal time base.
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned TICK_HZ       = 1_000;
    localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
    localparam int unsigned DIV_W         = 18;

    // Durations in milliseconds as built.
    localparam int unsigned RELEASE_STD_MS   = 200;
    localparam int unsigned RELEASE_SHORT_MS = 25;
    localparam int unsigned WDOG_SHORT_MS    = 200;
    localparam int unsigned WDOG_LONG_MS     = 1_600;

    // Counts of time-base ticks derived from the durations.
    localparam int unsigned RELEASE_STD_TICKS   = RELEASE_STD_MS * TICK_HZ / 1_000;
    localparam int unsigned RELEASE_SHORT_TICKS = RELEASE_SHORT_MS * TICK_HZ / 1_000;
    localparam int unsigned WDOG_SHORT_TICKS    = WDOG_SHORT_MS * TICK_HZ / 1_000;
    localparam int unsigned WDOG_LONG_TICKS     = WDOG_LONG_MS * TICK_HZ / 1_000;
    localparam int unsigned TICK_W              = 12;

    typedef enum logic [1:0] {
        ST_HOLD    = 2'b00,
        ST_RELEASE = 2'b01,
        ST_RUN     = 2'b10
    } ssw_state_t;

    // Synchronised pin levels.
    typedef struct packed {
        logic uv;
        logic man_n;
        logic kick;
    } ssw_pins_t;

    typedef struct packed {
        ssw_pins_t         s1;
        ssw_pins_t         s2;
        logic              kick_last;
        logic [DIV_W-1:0]  div;
        logic              tick;
        ssw_state_t        state;
        logic [TICK_W-1:0] rel_cnt;
        logic [TICK_W-1:0] wd_cnt;
        logic              rst_n;
        logic              rst;
    } ssw_regs_t;

endpackage

// *** dv/ssw_props.sv ***
// Checker of the reset output timing of the supervisor.
`timescale 1ns/1ps
module ssw_props import ssw_pkg::*; #(
    parameter bit          SHORT_RELEASE = 1'b0,
    parameter bit          SHORT_WDOG    = 1'b0,
    parameter int unsigned TICK_DIV_P    = TICK_DIV
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic UNDERVOLTAGE_I,
    input wire logic MANUAL_RESET_N_I,
    input wire logic WATCHDOG_KICK_IN_I,
    input wire logic RESET_N_O,
    input wire logic RESET_O
);
    localparam int REL = (SHORT_RELEASE ? RELEASE_SHORT_TICKS : RELEASE_STD_TICKS) * TICK_DIV_P;
    localparam int WD  = (SHORT_WDOG ? WDOG_SHORT_TICKS : WDOG_LONG_TICKS) * TICK_DIV_P;
    int unsigned clr_r;
    int unsigned kq_r;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    // Cycles since the last reset cause, and since the last kick edge or asserted reset.
    always_ff @(posedge SYS_CLK_I) begin
        clr_r <= (RST_I | UNDERVOLTAGE_I | !MANUAL_RESET_N_I) ? 0 : clr_r + 1;
        kq_r  <= (RST_I | !RESET_N_O | $changed(WATCHDOG_KICK_IN_I)) ? 0 : kq_r + 1;
    end
    a_out_compl: assert property (RESET_O != RESET_N_O) else $error("outputs agree");
    a_rst_hold: assert property ($fell(RST_I) |-> !RESET_N_O[*4]) else $error("no hold");
    a_uv_low: assert property (UNDERVOLTAGE_I[*6] |-> !RESET_N_O) else $error("uv");
    a_man_low: assert property (!MANUAL_RESET_N_I[*6] |-> !RESET_N_O) else $error("manual");
    a_rel_min: assert property ($rose(RESET_N_O) |-> clr_r >= REL - TICK_DIV_P)
        else $error("early release");
    a_rel_max: assert property (clr_r == REL + TICK_DIV_P + 12 |-> RESET_N_O)
        else $error("late release");
    a_wd_max: assert property (kq_r <= WD + TICK_DIV_P + 12) else $error("no bite");
    a_wd_min: assert property ($fell(RESET_N_O) |-> clr_r < 8 || kq_r >= WD - TICK_DIV_P - 2)
        else $error("early bite");
    cover property ($rose(RESET_N_O));
    cover property ($fell(RESET_N_O) && clr_r > 8);
    cover property ($fell(RESET_N_O) && !MANUAL_RESET_N_I);
endmodule
bind ssw_top ssw_props #(.SHORT_RELEASE(SHORT_RELEASE), .SHORT_WDOG(SHORT_WDOG),
    .TICK_DIV_P(TICK_DIV_P)) u_props (.SYS_CLK_I, .RST_I, .UNDERVOLTAGE_I,
    .MANUAL_RESET_N_I, .WATCHDOG_KICK_IN_I, .RESET_N_O, .RESET_O);

// *** dv/ssw_proc_model.sv ***
// Processor model that kicks the watchdog and pulls the manual reset.
`timescale 1ns/1ps
module ssw_proc_model (
    input  wire logic clk_i,
    input  wire logic kick_en_i,
    input  wire logic man_req_i,
    output logic      kick_o,
    output wire logic man_n_o
);
    logic [5:0] cnt_r = '0;
    initial kick_o = 1'b0;
    // Released pin floats, so the board pull-up decides its level.
    assign man_n_o = man_req_i ? 1'b0 : 1'bz;
    always @(posedge clk_i) begin
        cnt_r <= cnt_r + 6'h1;
        if (kick_en_i && cnt_r == 6'h0) kick_o <= #1 ~kick_o;
    end
endmodule

// *** dv/supply_supervisor_watchdog_tb.sv ***
// Testbench of the supply supervisor watchdog.
`timescale 1ns/1ps
module supply_supervisor_watchdog_tb;
    import ssw_pkg::*;
    localparam int REL = RELEASE_SHORT_TICKS * 4;
    localparam int WD  = WDOG_SHORT_TICKS * 4;
    logic clk = 1'b0, rst = 1'b1, uv = 1'b0, ken = 1'b1, mrq = 1'b0, kick, rn, ro;
    tri1  man_n;
    int   failures = 0, num_checks = 0, n;
    always #2.5 clk = ~clk;
    ssw_proc_model u_proc (.clk_i(clk), .kick_en_i(ken), .man_req_i(mrq), .kick_o(kick),
        .man_n_o(man_n));
    ssw_top #(.SHORT_RELEASE(1'b1), .SHORT_WDOG(1'b1), .TICK_DIV_P(4)) dut (.SYS_CLK_I(clk),
        .RST_I(rst), .UNDERVOLTAGE_I(uv), .MANUAL_RESET_N_I(man_n),
        .WATCHDOG_KICK_IN_I(kick), .RESET_N_O(rn), .RESET_O(ro));
    task automatic check(input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t reset output wrong", $time);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_out(input logic v);
        for (n = 0; rn !== v && n < 2000; n++) cyc(1);
    endtask
    task automatic t_power;
        rst = 1'b1;
        cyc(8);
        rst = 1'b0;
        check(rn, 1'b0);
        wait_out(1'b1);
        check(n inside {[REL-8:REL+12]}, 1'b1);
        check(ro, 1'b0);
        $display("power-up test end");
    endtask
    task automatic t_uv;
        uv = 1'b1;
        cyc(6);
        check(rn, 1'b0);
        uv = 1'b0;
        cyc(REL / 2);
        uv = 1'b1;
        cyc(1);
        uv = 1'b0;
        wait_out(1'b1);
        check(n inside {[REL-8:REL+12]}, 1'b1);
        $display("undervoltage test end");
    endtask
    task automatic t_mr;
        mrq = 1'b1;
        cyc(20);
        check(rn, 1'b0);
        mrq = 1'b0;
        wait_out(1'b1);
        check(n inside {[REL-8:REL+12]}, 1'b1);
        $display("manual reset test end");
    endtask
    task automatic t_wd;
        cyc(3 * WD);
        check(rn, 1'b1);
        ken = 1'b0;
        wait_out(1'b0);
        check(n inside {[WD-70:WD+15]}, 1'b1);
        ken = 1'b1;
        wait_out(1'b1);
        check(n inside {[REL-8:REL+12]}, 1'b1);
        $display("watchdog test end");
    endtask
    task automatic wrap_up;
        $display("checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        t_power;
        t_uv;
        t_mr;
        t_wd;
        t_power;
        wrap_up;
    end
    initial begin
        #60us;
        failures++;
        wrap_up;
    end
endmodule
